// file: src/fpc_flash_ctrl.sv
// Summary of operation
// [R1] latch map off: user array read-only
// [R2] mapped writes fill latches, page from bits 14:7
// [R3] latch map beats external ram select
// [R4] space select picks user, row, security, reserved
// [R5] key 5 then A launches programming
// [R6] security space programs fuse; reserved does nothing
// [R7] busy blocks fetch, cpu idles until done
// [R8] busy set and cleared by hardware only
// [R9] software masks interrupts across programming
// [R10] latches accept one to 128 bytes
// [R11] erase then program only loaded bytes
// [R12] last latch write page is target
// [R13] launch pairs 50/A0, 52/A2, 54/A4
// [R14] security write: 0Ch, store at 0000h, launch
// [R15] read view via 00h, 02h, 04h
// [R16] security upper nibble software, lower parallel only
// [R17] boot enable maps boot array at F400h
// [R18] extra row is 128 bytes from FF80h
// [R19] control byte: key, map, select, busy
// [R20] non-A after 5 abandons unlock
//
// Chosen here: the Wishbone register port and the address map.
`include "fpc_defines.svh"
module fpc_flash_ctrl
  import fpc_pkg::*;
#(
  parameter int USER_BYTES = 32768,
  parameter int BOOT_BYTES = 3072,
  parameter int PAGE_BYTES = 128,
  parameter int PROG_CYCLES = `FPC_PROG_TIME_US * `FPC_CLK_MHZ,
  parameter logic [7:0] BOOT_FILL = 8'hFF
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  fpc_link_if.flash LINK,
  input wire logic PAR_SEC_WR,
  input wire logic [3:0] PAR_SEC_DATA,
  output logic PROG_ACTIVE
);
  localparam int UAW = $clog2(USER_BYTES);
  localparam int PAW = $clog2(PAGE_BYTES);

  logic [7:1] ctrl; // key, map bit, space select
  logic busy;
  logic armed;
  fpc_state_type state;
  logic [PAW-1:0] idx;
  logic [31:0] timer;
  fpc_space_type tgt;
  logic [7:0] page;
  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] extra_config_row_mem [PAGE_BYTES];
  logic [7:0] sec_byte;
  logic [7:0] lat_rdata;
  logic lat_loaded;
  logic lat_any;
  logic lat_wr;
  logic lat_clr;
  logic [PAW-1:0] lat_waddr;
  logic launch;
  logic [3:0] key;
  fpc_space_type mode;
  logic [UAW-1:0] prog_addr;

  // address falls in the latch window of the selected space
  function automatic logic in_latch_window(input fpc_space_type sp, input logic [15:0] a);
    case (sp)
      FPC_SP_USER: in_latch_window = ~a[`FPC_USER_TOP_BIT];
      FPC_SP_EXTRA_CONFIG_ROW: in_latch_window = (a >= `FPC_EXTRA_CONFIG_ROW_BASE);
      FPC_SP_SEC: in_latch_window = (a == `FPC_SEC_ADDR);
      default: in_latch_window = 1'b0;
    endcase
  endfunction : in_latch_window

  assign key = LINK.ctrl_wdata[`FPC_KEY_HI:`FPC_KEY_LO];
  assign mode = fpc_space_type'(ctrl[`FPC_MODE_HI:`FPC_MODE_LO]);
  assign launch = LINK.ctrl_wr && armed && (key == `FPC_KEY_GO) && !busy
    && (LINK.ctrl_wdata[`FPC_MODE_HI:`FPC_MODE_LO] != FPC_SP_RSVD); // see [R5] see [R6]
  // latch loads only while mapped; otherwise data goes to ram
  assign lat_wr = LINK.data_wr && ctrl[`FPC_MAP_BIT] && in_latch_window(mode, LINK.data_addr)
    && !busy; // see [R2] see [R10]
  assign lat_waddr = (mode == FPC_SP_SEC) ? '0 : LINK.data_addr[PAW-1:0]; // see [R18]
  assign lat_clr = (state == FPC_ST_WAIT) && (timer >= PROG_CYCLES - 1);
  assign prog_addr = UAW'({page, idx});

  fpc_col_latch #(.DEPTH(PAGE_BYTES), .AW(PAW)) u_latch (
    .clk(SYS_CLK),
    .srst(SRST),
    .wr(lat_wr),
    .waddr(lat_waddr),
    .wdata(LINK.data_wdata),
    .clr(lat_clr),
    .raddr(idx),
    .rdata(lat_rdata),
    .rloaded(lat_loaded),
    .any_loaded(lat_any)
  );

  // control byte; busy bit is not software writable
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl <= 7'(`FPC_CTRL_RST >> 1);
    end else if (LINK.ctrl_wr) begin
      ctrl <= LINK.ctrl_wdata[7:1]; // see [R19] see [R8]
    end
  end

  // unlock sequence tracking
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      armed <= 1'b0;
    end else if (LINK.ctrl_wr) begin
      armed <= (key == `FPC_KEY_ARM); // see [R5] see [R20]
    end
  end

  // page of the most recent latch write in user space
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      page <= '0;
    end else if (lat_wr && mode == FPC_SP_USER) begin
      page <= LINK.data_addr[`FPC_PAGE_HI:`FPC_PAGE_LO]; // see [R12]
    end
  end

  // programming sequencer: erase walk, program walk, wait out time
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state <= FPC_ST_IDLE;
      busy <= 1'b0;
      idx <= '0;
      timer <= '0;
      tgt <= FPC_SP_USER;
    end else begin
      timer <= (state == FPC_ST_IDLE) ? '0 : timer + 32'h1;
      case (state)
        FPC_ST_IDLE: begin
          if (launch) begin
            state <= FPC_ST_ERASE;
            busy <= 1'b1; // see [R7] see [R8]
            idx <= '0;
            tgt <= fpc_space_type'(LINK.ctrl_wdata[`FPC_MODE_HI:`FPC_MODE_LO]);
          end
        end
        FPC_ST_ERASE: begin
          idx <= idx + 1'b1;
          if (idx == `FPC_LAST_IDX) begin
            state <= FPC_ST_PROG; // see [R11]
          end
        end
        FPC_ST_PROG: begin
          idx <= idx + 1'b1;
          if (idx == `FPC_LAST_IDX) begin
            state <= FPC_ST_WAIT;
          end
        end
        FPC_ST_WAIT: begin
          if (lat_clr) begin
            state <= FPC_ST_IDLE;
            busy <= 1'b0; // see [R8]
          end
        end
        default: state <= FPC_ST_IDLE;
      endcase
    end
  end

  // user array: only loaded bytes erased then written
  always_ff @(posedge SYS_CLK) begin
    if (tgt == FPC_SP_USER && lat_loaded) begin
      if (state == FPC_ST_ERASE) begin
        user_mem[prog_addr] <= `FPC_ERASED; // see [R11]
      end else if (state == FPC_ST_PROG) begin
        user_mem[prog_addr] <= lat_rdata;
      end
    end
  end

  // extra row array
  always_ff @(posedge SYS_CLK) begin
    if (tgt == FPC_SP_EXTRA_CONFIG_ROW && lat_loaded) begin
      if (state == FPC_ST_ERASE) begin
        extra_config_row_mem[idx] <= `FPC_ERASED; // see [R18]
      end else if (state == FPC_ST_PROG) begin
        extra_config_row_mem[idx] <= lat_rdata;
      end
    end
  end

  // security byte: software touches upper nibble, parallel port the lower
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sec_byte <= `FPC_SEC_RST;
    end else if (tgt == FPC_SP_SEC && lat_loaded && idx == '0 && state == FPC_ST_ERASE) begin
      sec_byte <= sec_byte | `FPC_SEC_SW_MASK; // see [R6] see [R16]
    end else if (tgt == FPC_SP_SEC && lat_loaded && idx == '0 && state == FPC_ST_PROG) begin
      sec_byte <= (sec_byte & ~`FPC_SEC_SW_MASK) | (lat_rdata & `FPC_SEC_SW_MASK); // see [R16]
    end else if (PAR_SEC_WR) begin
      sec_byte <= {sec_byte[7:4], PAR_SEC_DATA}; // see [R16]
    end
  end

  // code reads answered only while not busy
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      LINK.code_ack <= 1'b0;
      LINK.code_rdata <= '0;
    end else begin
      LINK.code_ack <= LINK.code_req && !busy && !LINK.code_ack; // see [R7]
      // data loads only with the answer and then holds
      if (LINK.code_req && !busy && !LINK.code_ack) begin
        case (mode)
          FPC_SP_USER: begin
            if (LINK.boot_en && LINK.data_addr >= `FPC_BOOT_BASE) begin
              LINK.code_rdata <= BOOT_FILL; // see [R17]
            end else begin
              LINK.code_rdata <= user_mem[LINK.data_addr[UAW-1:0]]; // see [R1] see [R4]
            end
          end
          FPC_SP_EXTRA_CONFIG_ROW: LINK.code_rdata <= extra_config_row_mem[LINK.data_addr[PAW-1:0]]; // see [R4]
          FPC_SP_SEC: LINK.code_rdata <= sec_byte; // see [R4]
          default: LINK.code_rdata <= `FPC_ERASED;
        endcase
      end
    end
  end

  // data writes go to ram only while the map bit is clear; map bit has priority
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      LINK.ram_wr <= 1'b0;
      LINK.ram_wr_ext <= 1'b0;
    end else begin
      LINK.ram_wr <= LINK.data_wr && !ctrl[`FPC_MAP_BIT] && !LINK.ext_ram_sel; // see [R3]
      LINK.ram_wr_ext <= LINK.data_wr && !ctrl[`FPC_MAP_BIT] && LINK.ext_ram_sel; // see [R3]
    end
  end

  assign LINK.ctrl_rdata = {ctrl, busy};
  assign LINK.cpu_idle = busy; // see [R7]
  assign PROG_ACTIVE = busy;
endmodule : fpc_flash_ctrl

// file: src/fpc_defines.svh
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// flash control byte layout
`define FPC_KEY_HI 7
`define FPC_KEY_LO 4
`define FPC_MAP_BIT 3
`define FPC_MODE_HI 2
`define FPC_MODE_LO 1
`define FPC_BUSY_BIT 0
`define FPC_CTRL_RST 8'h00
`define FPC_KEY_ARM 4'h5
`define FPC_KEY_GO 4'hA
// address map
`define FPC_USER_TOP_BIT 15
`define FPC_PAGE_HI 14
`define FPC_PAGE_LO 7
`define FPC_EXTRA_CONFIG_ROW_BASE 16'hFF80
`define FPC_BOOT_BASE 16'hF400
`define FPC_SEC_ADDR 16'h0000
`define FPC_ERASED 8'hFF
`define FPC_SEC_SW_MASK 8'hF0
`define FPC_SEC_RST 8'hFF
`define FPC_LAST_IDX 7'h7F
// programming time
`define FPC_PROG_TIME_US 10000
`define FPC_CLK_MHZ 125
// wishbone register offsets of the cpu port
`define FPC_REG_CTRL 8'h00
`define FPC_REG_AUX 8'h04
`define FPC_REG_DADDR 8'h08
`define FPC_REG_DWDATA 8'h0C
`define FPC_REG_CREAD 8'h10
`define FPC_REG_STATUS 8'h14
`define FPC_AUX_BOOT_BIT 0
`define FPC_AUX_XRAM_BIT 1
`endif

// file: src/fpc_pkg.sv
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_SP_USER = 2'h0,
    FPC_SP_EXTRA_CONFIG_ROW = 2'h1,
    FPC_SP_SEC = 2'h2,
    FPC_SP_RSVD = 2'h3
  } fpc_space_type;
  typedef enum logic [3:0] {
    FPC_ST_IDLE = 4'b0001,
    FPC_ST_ERASE = 4'b0010,
    FPC_ST_PROG = 4'b0100,
    FPC_ST_WAIT = 4'b1000
  } fpc_state_type;
endpackage : fpc_pkg

// file: src/fpc_link_if.sv
interface fpc_link_if;
  logic ctrl_wr; // control byte write strobe
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata; // control byte readback with busy flag
  logic boot_en; // boot_space_enable
  logic ext_ram_sel; // ext_ram_select
  logic data_wr; // data space write strobe
  logic [15:0] data_addr;
  logic [7:0] data_wdata;
  logic ram_wr; // data write passed to normal ram
  logic ram_wr_ext; // data write passed to external ram
  logic code_req; // code read request, held until ack
  logic code_ack;
  logic [7:0] code_rdata;
  logic cpu_idle; // cpu held in idle while programming
  modport cpu (output ctrl_wr, ctrl_wdata, boot_en, ext_ram_sel, data_wr, data_addr, data_wdata, code_req,
    input ctrl_rdata, ram_wr, ram_wr_ext, code_ack, code_rdata, cpu_idle);
  modport flash (input ctrl_wr, ctrl_wdata, boot_en, ext_ram_sel, data_wr, data_addr, data_wdata, code_req,
    output ctrl_rdata, ram_wr, ram_wr_ext, code_ack, code_rdata, cpu_idle);
endinterface : fpc_link_if

// file: src/fpc_col_latch.sv
module fpc_col_latch #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic clr,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata,
  output logic rloaded,
  output logic any_loaded
);
  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] loaded;

  // byte store, any count of bytes per page
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
  end

  // loaded marks, cleared after programming
  always_ff @(posedge clk) begin
    if (srst || clr) begin
      loaded <= '0;
    end else if (wr) begin
      loaded[waddr] <= 1'b1;
    end
  end

  assign rdata = mem[raddr];
  assign rloaded = loaded[raddr];
  assign any_loaded = |loaded;
endmodule : fpc_col_latch

// file: src/fpc_cpu_port.sv
`include "fpc_defines.svh"
module fpc_cpu_port
  import fpc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  fpc_link_if.cpu LINK
);
  logic req;
  logic stall;
  logic wr;
  logic [1:0] aux;
  logic [15:0] daddr;
  logic rd_done;
  logic [31:0] rmux;

  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // cpu stalls control and data writes while idle in programming
  assign stall = LINK.cpu_idle && WB_WE_I
    && (WB_ADR_I == `FPC_REG_CTRL || WB_ADR_I == `FPC_REG_DWDATA); // see [R9]
  assign wr = req && !stall && WB_WE_I && WB_SEL_I[0];

  // ack one cycle after request, or one cycle after a stall ends
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && !stall;
    end
  end

  // read data registered with ack
  always_comb begin
    rmux = '0;
    if (WB_ADR_I == `FPC_REG_CTRL) begin
      rmux = {24'h0, LINK.ctrl_rdata};
    end else if (WB_ADR_I == `FPC_REG_AUX) begin
      rmux = {30'h0, aux};
    end else if (WB_ADR_I == `FPC_REG_DADDR) begin
      rmux = {16'h0, daddr};
    end else if (WB_ADR_I == `FPC_REG_DWDATA) begin
      rmux = {24'h0, LINK.data_wdata};
    end else if (WB_ADR_I == `FPC_REG_CREAD) begin
      rmux = {22'h0, rd_done, LINK.code_req, LINK.code_rdata};
    end else if (WB_ADR_I == `FPC_REG_STATUS) begin
      rmux = {31'h0, LINK.cpu_idle};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      WB_DAT_O <= '0;
    end else if (req && !stall) begin
      WB_DAT_O <= rmux;
    end
  end

  // control byte and data write strobes
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      LINK.ctrl_wr <= 1'b0;
      LINK.ctrl_wdata <= '0;
      LINK.data_wr <= 1'b0;
      LINK.data_wdata <= '0;
    end else begin
      LINK.ctrl_wr <= wr && WB_ADR_I == `FPC_REG_CTRL; // see [R13] see [R15]
      LINK.data_wr <= wr && WB_ADR_I == `FPC_REG_DWDATA; // see [R14]
      if (wr && WB_ADR_I == `FPC_REG_CTRL) begin
        LINK.ctrl_wdata <= WB_DAT_I[7:0];
      end
      if (wr && WB_ADR_I == `FPC_REG_DWDATA) begin
        LINK.data_wdata <= WB_DAT_I[7:0];
      end
    end
  end

  // aux selects and data pointer
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      aux <= '0;
      daddr <= '0;
    end else begin
      if (wr && WB_ADR_I == `FPC_REG_AUX) begin
        aux <= WB_DAT_I[1:0];
      end
      if (wr && WB_ADR_I == `FPC_REG_DADDR) begin
        daddr[7:0] <= WB_DAT_I[7:0];
      end
      if (req && !stall && WB_WE_I && WB_SEL_I[1] && WB_ADR_I == `FPC_REG_DADDR) begin
        daddr[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // code read handshake; request held until the flash answers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      LINK.code_req <= 1'b0;
      rd_done <= 1'b0;
    end else if (LINK.code_ack) begin
      LINK.code_req <= 1'b0;
      rd_done <= 1'b1;
    end else if (wr && WB_ADR_I == `FPC_REG_CREAD) begin
      LINK.code_req <= 1'b1;
      rd_done <= 1'b0;
    end
  end

  assign LINK.boot_en = aux[`FPC_AUX_BOOT_BIT];
  assign LINK.ext_ram_sel = aux[`FPC_AUX_XRAM_BIT];
  assign LINK.data_addr = daddr;
endmodule : fpc_cpu_port

// file: tb/fpc_flash_assertions.sv
module fpc_flash_assertions #(
  parameter int PROG_CYCLES = 400
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic ext_ram_sel,
  input wire logic data_wr,
  input wire logic ram_wr,
  input wire logic ram_wr_ext,
  input wire logic code_req,
  input wire logic code_ack,
  input wire logic cpu_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed;
  int cnt;
  logic busy;
  logic go;
  // busy flag and second key write
  assign busy = ctrl_rdata[0];
  assign go = ctrl_wr && ctrl_wdata[7:4] == 4'hA && !busy;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // remembers a first key write
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      armed <= 1'b0;
    end else if (ctrl_wr) begin
      armed <= ctrl_wdata[7:4] == 4'h5;
    end
  end
  // cycles spent busy
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !busy) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  a_launch_busy: assert property (go && armed && ctrl_wdata[2:1] != 2'h3 |=> busy)
    else $error("launch did not set busy");
  a_rsvd_none: assert property (go && ctrl_wdata[2:1] == 2'h3 |=> !busy)
    else $error("reserved space launched");
  a_unarmed_none: assert property (go && !armed |=> !busy)
    else $error("launch without first key");
  a_idle_busy: assert property (busy |-> cpu_idle)
    else $error("cpu not idle while busy");
  a_no_fetch: assert property (cpu_idle && $past(cpu_idle) |-> !code_ack)
    else $error("code answered while busy");
  a_busy_long: assert property ($fell(busy) |-> cnt >= 256)
    else $error("busy too short");
  a_busy_ends: assert property (cnt <= PROG_CYCLES + 4)
    else $error("busy never cleared");
  a_map_wins: assert property (data_wr && ctrl_rdata[3] |=> !ram_wr && !ram_wr_ext)
    else $error("mapped write reached ram");
  a_ram_route: assert property (data_wr && !ctrl_rdata[3] |=>
    ram_wr_ext == $past(ext_ram_sel) && ram_wr != $past(ext_ram_sel))
    else $error("data write misrouted");
  a_fetch_ans: assert property ($rose(code_req) && !cpu_idle |=> code_ack)
    else $error("code read not answered");
  a_ctrl_fields: assert property (ctrl_wr && !busy |=> ctrl_rdata[3:1] == $past(ctrl_wdata[3:1]))
    else $error("control fields not stored");
  c_launch: cover property (go && armed);
  c_done: cover property ($fell(busy));
  c_ext: cover property (ram_wr_ext);
  c_fetch: cover property (code_ack);
endmodule : fpc_flash_assertions

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic psw = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] psd = 4'h0;
  logic [31:0] dr;
  logic ack;
  logic pa;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  int errors = 0;
  int checks = 0;
  logic [15:0] pg;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  fpc_link_if link();
  fpc_cpu_port fpc_cpu_port_i (.SYS_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dw), .WB_SEL_I(sel), .WB_DAT_O(dr), .WB_ACK_O(ack), .LINK(link.cpu));
  fpc_flash_ctrl #(.PROG_CYCLES(400)) fpc_flash_ctrl_i (.SYS_CLK(clk), .SRST(srst), .LINK(link.flash),
    .PAR_SEC_WR(psw), .PAR_SEC_DATA(psd), .PROG_ACTIVE(pa));
  fpc_flash_assertions #(.PROG_CYCLES(400)) fpc_flash_assertions_i (.SYS_CLK(clk), .SRST(srst),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
    .ext_ram_sel(link.ext_ram_sel), .data_wr(link.data_wr), .ram_wr(link.ram_wr),
    .ram_wr_ext(link.ram_wr_ext), .code_req(link.code_req), .code_ack(link.code_ack),
    .cpu_idle(link.cpu_idle));
  // free running clock
  always #4 clk = ~clk;
  // one classic cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // code read through the cpu port
  task cr(input logic [15:0] a, input logic [7:0] x);
    wr(8'h08, {16'h0, a});
    wr(8'h10, 32'h0);
    repeat (2) @(posedge clk);
    rd(8'h10, {22'h0, 2'b10, x});
  endtask : cr
  task ld(input logic [15:0] a, input logic [7:0] d);
    wr(8'h08, {16'h0, a});
    wr(8'h0C, {24'h0, d});
  endtask : ld
  task go(input logic [1:0] m);
    wr(8'h00, {24'h0, 4'h5, 1'b0, m, 1'b0});
    wr(8'h00, {24'h0, 4'hA, 1'b0, m, 1'b0});
  endtask : go
  // direct look at the programming-active pin
  task chk_pa(input logic x);
    checks++;
    if (pa !== x) begin
      errors++;
      $display("Error PROG_ACTIVE expected %0b seen %0b", x, pa);
    end
  endtask : chk_pa
  task final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // compares each acked read with the oldest note
  always @(posedge clk) begin
    if (cyc && !we && ack === 1'b1) begin
      e = exp_q.pop_front();
      checks++;
      if (dr !== e) begin
        errors++;
        $display("Error WB_DAT_O at %0h expected %0h seen %0h", adr, e, dr);
      end
    end
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(28));
    pg = {1'b0, 8'($urandom), 7'h00};
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    // byte 5 loaded under another page, last page decides
    wr(8'h00, 32'h08);
    ld((pg ^ 16'h0080) | 16'h0005, b2);
    ld(pg, b0);
    ld(pg | 16'h007F, b1);
    go(2'h0);
    rd(8'h14, 32'h1);
    chk_pa(1'b1);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    chk_pa(1'b0);
    cr(pg, b0);
    cr(pg | 16'h007F, b1);
    cr(pg | 16'h0005, b2);
    // second pass touches byte 0 only
    wr(8'h00, 32'h08);
    ld(pg, ~b0);
    go(2'h0);
    // fetch asked while busy stays pending, old data held
    wr(8'h10, 32'h0);
    rd(8'h10, {22'h0, 2'b01, b2});
    wr(8'h00, 32'h0);
    cr(pg, ~b0);
    cr(pg | 16'h007F, b1);
    // broken and reserved unlocks
    wr(8'h00, 32'h50);
    wr(8'h00, 32'h08);
    wr(8'h00, 32'hA0);
    rd(8'h14, 32'h0);
    go(2'h3);
    rd(8'h14, 32'h0);
    // extra row
    wr(8'h00, 32'h0A);
    ld(16'hFF80, b1);
    ld(16'hFFFF, b2);
    go(2'h1);
    wr(8'h00, 32'h02);
    cr(16'hFF80, b1);
    cr(16'hFFFF, b2);
    // security byte, then parallel low nibble
    wr(8'h00, 32'h0C);
    ld(16'h0000, b0);
    go(2'h2);
    wr(8'h00, 32'h04);
    cr(16'h0000, {b0[7:4], 4'hF});
    @(posedge clk);
    psw <= 1'b1;
    psd <= b1[3:0];
    @(posedge clk);
    psw <= 1'b0;
    cr(16'h0000, {b0[7:4], b1[3:0]});
    // reserved view and boot overlay
    wr(8'h00, 32'h06);
    cr(pg, 8'hFF);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    cr(16'hF400, 8'hFF);
    cr(pg, ~b0);
    // ram routing with external select, unmapped place
    wr(8'h04, 32'h2);
    ld(16'h1234, b0);
    wr(8'h00, 32'h08);
    ld(16'h1234, b0);
    wr(8'h1C, 32'hFFFF);
    rd(8'h1C, 32'h0);
    final_report();
  end
endmodule : testbench
